// ==== ckgen_map.svh ====
// register offsets, field positions, reset values and timing counts of the reset/power-down block
`ifndef CKGEN_MAP_SVH
`define CKGEN_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_SERCFG 10'h000
`define ADDR_READSEL 10'h004
`define ADDR_STATUS 10'h006
`define ADDR_PLLCTL 10'h010
`define ADDR_ECL_BASE 10'h0F0
`define ADDR_LS_BASE 10'h140
`define ADDR_DISTCTL 10'h230
`define ADDR_UPDATE 10'h232
`define NUM_ECL 6
`define NUM_LS 4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SOFT_RST_HI_BIT 5
`define SOFT_RST_LO_BIT 2
`define READ_ACTIVE_BIT 0
`define PLL_MODE_LSB 0
`define ECL_MODE_LSB 0
`define ECL_AMP_LSB 2
`define ECL_INV_BIT 4
`define LS_PD_BIT 0
`define LS_SE_BIT 3
`define LS_B_EN_BIT 4
`define LS_POL_LSB 5
`define DIST_ALIGN_BIT 0
`define DIST_PD_BIT 1
`define UPDATE_BIT 0

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define PLL_MODE_NORMAL 2'h0
`define PLL_MODE_ASYNC 2'h1
`define PLL_MODE_SYNC 2'h3
`define ECL_MODE_NORMAL 2'h0
`define ECL_MODE_SAFE 2'h2
`define ECL_MODE_TOTAL 2'h3
`define PLLCTL_DEFAULT 8'h00
`define ECL_CTL_DEFAULT 8'h08
`define LS_CTL_DEFAULT 8'h00
`define DISTCTL_DEFAULT 8'h00
`define READSEL_DEFAULT 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define ALIGN_TIME_NS 64
`define ALIGN_CYCLES ((`ALIGN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== ckgen_pkg.sv ====
// types shared by the reset/power-down block
package ckgen_pkg;
    typedef enum logic [1:0] {PLL_ON, PLL_WAIT_CP, PLL_OFF} pll_state_t;
    typedef logic [7:0] reg_byte_t;
    typedef logic [3:0] align_cnt_t;
endpackage

// ==== sync_2ff.sv ====
// two-flop level synchroniser, resets to zero
`timescale 1ns/1ps
module sync_2ff (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    logic meta_ff;
    logic q_ff;

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_ff <= 1'b0;
            q_ff <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule

// ==== hold_stretch.sv ====
// holds busy while the request stands and for a fixed count after it drops
`timescale 1ns/1ps
`include "ckgen_map.svh"
module hold_stretch (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // request and busy
    input wire logic hold_i,
    output logic busy_o
);
    ckgen_pkg::align_cnt_t cnt_ff;
    ckgen_pkg::align_cnt_t nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (hold_i) begin
            nxt_cnt = 4'(`ALIGN_CYCLES);
        end else if (cnt_ff != 4'h0) begin
            nxt_cnt = cnt_ff - 4'h1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign busy_o = hold_i || (cnt_ff != 4'h0);
endmodule

// ==== clock_gen_reset_powerdown_ctrl.sv ====
// reset, power-down and output enable control of the multi-output clock generator
// ----------------------------------------------------------------
// Behaviour
// - power-on loads every register with its default and makes it active
// - power-on also runs an output alignment
// - low reset pin asynchronously returns all registers to defaults
// - soft reset: write both mirrored bits one, then zero; defaults held meanwhile
// - soft reset bits act at once, without an update
// - sleep pin low keeps the chip asleep until it returns high
// - waking resumes register contents, including writes made while asleep
// - asleep: pll, oscillator, input buffer, dividers, low-swing off; ecl safe-off
// - register port stays fully working while asleep
// - two-bit pll field selects normal, async or sync power-down
// - async mode turns pll off as soon as the update lands
// - sync mode waits for the next charge pump event after update
// - distribution power-down bit removes bias from distribution
// - ecl mode per output: 00 normal, 10 safe, 11 total; also used in dist pd
// - each ecl output has its own power-down and polarity
// - each ecl output has a two-bit swing select
// - single-ended mode turns output a on; output b has its own enable
// - one power-down bit kills differential and both single-ended outputs
// - three-bit polarity field per low-swing output in single-ended mode
// - soft align, soft reset, dist pd, reset or sleep release each align outputs
// - buffered writes go active together on the self-clearing update bit
// ----------------------------------------------------------------
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "ckgen_map.svh"
module clock_gen_reset_powerdown_ctrl (
    // clock and hard reset pin
    input wire logic mclk_i,
    input wire logic rstn_i,
    // pins
    input wire logic chip_sleep_n_i,
    input wire logic cp_event_i,
    // register port
    input wire logic [9:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // core power controls
    output logic pll_pwr_dn_o,
    output logic osc_pwr_dn_o,
    output logic clkin_buf_pwr_dn_o,
    output logic div_pwr_dn_o,
    output logic dist_bias_off_o,
    output logic align_o,
    output logic soft_rst_active_o,
    // ecl outputs, two bits or one bit per output
    output logic [11:0] ecl_pd_mode_o,
    output logic [11:0] ecl_amp_o,
    output logic [5:0] ecl_invert_o,
    output logic [5:0] ecl_enable_o,
    // low-swing outputs
    output logic [3:0] ls_pwr_dn_o,
    output logic [3:0] ls_diff_en_o,
    output logic [3:0] ls_cmos_a_en_o,
    output logic [3:0] ls_cmos_b_en_o,
    output logic [11:0] ls_polarity_o
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic sleep_n_sync;
    logic rst_released;
    logic align_busy;
    logic sleep;

    sync_2ff u_sleep_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .d_i(chip_sleep_n_i),
        .q_o(sleep_n_sync)
    );

    // release of the reset pin seen two edges late, so alignment starts cleanly
    sync_2ff u_rst_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .d_i(1'b1),
        .q_o(rst_released)
    );

    // a synchronised sleep_n of zero right after reset reads as asleep until it settles
    assign sleep = !sleep_n_sync;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic soft_rst_ff;
    logic nxt_soft_rst;
    ckgen_pkg::reg_byte_t readsel_ff, nxt_readsel;
    ckgen_pkg::reg_byte_t pll_buf_ff, nxt_pll_buf;
    ckgen_pkg::reg_byte_t pll_act_ff, nxt_pll_act;
    ckgen_pkg::reg_byte_t dist_buf_ff, nxt_dist_buf;
    ckgen_pkg::reg_byte_t dist_act_ff, nxt_dist_act;
    ckgen_pkg::reg_byte_t ecl_buf_ff [`NUM_ECL];
    ckgen_pkg::reg_byte_t ecl_act_ff [`NUM_ECL];
    ckgen_pkg::reg_byte_t ls_buf_ff [`NUM_LS];
    ckgen_pkg::reg_byte_t ls_act_ff [`NUM_LS];
    ckgen_pkg::reg_byte_t nxt_ecl_buf [`NUM_ECL];
    ckgen_pkg::reg_byte_t nxt_ecl_act [`NUM_ECL];
    ckgen_pkg::reg_byte_t nxt_ls_buf [`NUM_LS];
    ckgen_pkg::reg_byte_t nxt_ls_act [`NUM_LS];
    ckgen_pkg::reg_byte_t rdata_ff, nxt_rdata;
    logic update;

    always_comb begin
        nxt_soft_rst = soft_rst_ff;
        nxt_readsel = readsel_ff;
        nxt_pll_buf = pll_buf_ff;
        nxt_pll_act = pll_act_ff;
        nxt_dist_buf = dist_buf_ff;
        nxt_dist_act = dist_act_ff;
        nxt_ecl_buf = ecl_buf_ff;
        nxt_ecl_act = ecl_act_ff;
        nxt_ls_buf = ls_buf_ff;
        nxt_ls_act = ls_act_ff;
        update = 1'b0;
        // writes are taken whether asleep or not
        if (reg_wr_i) begin
            if (reg_addr_i == `ADDR_SERCFG) begin
                // mirrored pair, either half sets it; acts directly
                nxt_soft_rst = reg_wdata_i[`SOFT_RST_HI_BIT]
                    | reg_wdata_i[`SOFT_RST_LO_BIT];
            end
            if (reg_addr_i == `ADDR_READSEL) begin
                nxt_readsel = reg_wdata_i;
            end
            if (reg_addr_i == `ADDR_PLLCTL) begin
                nxt_pll_buf = reg_wdata_i;
            end
            if (reg_addr_i == `ADDR_DISTCTL) begin
                nxt_dist_buf = reg_wdata_i;
            end
            for (int i = 0; i < `NUM_ECL; i++) begin
                if (reg_addr_i == `ADDR_ECL_BASE + 10'(i)) begin
                    nxt_ecl_buf[i] = reg_wdata_i;
                end
            end
            for (int i = 0; i < `NUM_LS; i++) begin
                if (reg_addr_i == `ADDR_LS_BASE + 10'(i)) begin
                    nxt_ls_buf[i] = reg_wdata_i;
                end
            end
            update = (reg_addr_i == `ADDR_UPDATE) && reg_wdata_i[`UPDATE_BIT];
        end
        // all pending buffer contents go active in the same edge
        if (update) begin
            nxt_pll_act = pll_buf_ff;
            nxt_dist_act = dist_buf_ff;
            nxt_ecl_act = ecl_buf_ff;
            nxt_ls_act = ls_buf_ff;
        end
        // defaults pinned while soft reset stands; other writes are lost meanwhile
        if (soft_rst_ff) begin
            nxt_readsel = `READSEL_DEFAULT;
            nxt_pll_buf = `PLLCTL_DEFAULT;
            nxt_pll_act = `PLLCTL_DEFAULT;
            nxt_dist_buf = `DISTCTL_DEFAULT;
            nxt_dist_act = `DISTCTL_DEFAULT;
            for (int i = 0; i < `NUM_ECL; i++) begin
                nxt_ecl_buf[i] = `ECL_CTL_DEFAULT;
                nxt_ecl_act[i] = `ECL_CTL_DEFAULT;
            end
            for (int i = 0; i < `NUM_LS; i++) begin
                nxt_ls_buf[i] = `LS_CTL_DEFAULT;
                nxt_ls_act[i] = `LS_CTL_DEFAULT;
            end
        end
    end

    // sleep does not touch these, so waking resumes them as they stand
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            soft_rst_ff <= 1'b0;
            readsel_ff <= `READSEL_DEFAULT;
            pll_buf_ff <= `PLLCTL_DEFAULT;
            pll_act_ff <= `PLLCTL_DEFAULT;
            dist_buf_ff <= `DISTCTL_DEFAULT;
            dist_act_ff <= `DISTCTL_DEFAULT;
            for (int i = 0; i < `NUM_ECL; i++) begin
                ecl_buf_ff[i] <= `ECL_CTL_DEFAULT;
                ecl_act_ff[i] <= `ECL_CTL_DEFAULT;
            end
            for (int i = 0; i < `NUM_LS; i++) begin
                ls_buf_ff[i] <= `LS_CTL_DEFAULT;
                ls_act_ff[i] <= `LS_CTL_DEFAULT;
            end
        end else begin
            soft_rst_ff <= nxt_soft_rst;
            readsel_ff <= nxt_readsel;
            pll_buf_ff <= nxt_pll_buf;
            pll_act_ff <= nxt_pll_act;
            dist_buf_ff <= nxt_dist_buf;
            dist_act_ff <= nxt_dist_act;
            ecl_buf_ff <= nxt_ecl_buf;
            ecl_act_ff <= nxt_ecl_act;
            ls_buf_ff <= nxt_ls_buf;
            ls_act_ff <= nxt_ls_act;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic rd_act;

    always_comb begin
        rd_act = readsel_ff[`READ_ACTIVE_BIT];
        nxt_rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `ADDR_SERCFG: begin
                    nxt_rdata = {2'h0, soft_rst_ff, 2'h0, soft_rst_ff, 2'h0};
                end
                `ADDR_READSEL: begin
                    nxt_rdata = readsel_ff;
                end
                `ADDR_STATUS: begin
                    nxt_rdata = {4'h0, soft_rst_ff, align_busy, pll_pwr_dn_o, sleep};
                end
                `ADDR_PLLCTL: begin
                    nxt_rdata = rd_act ? pll_act_ff : pll_buf_ff;
                end
                `ADDR_DISTCTL: begin
                    nxt_rdata = rd_act ? dist_act_ff : dist_buf_ff;
                end
                default: begin
                    for (int i = 0; i < `NUM_ECL; i++) begin
                        if (reg_addr_i == `ADDR_ECL_BASE + 10'(i)) begin
                            nxt_rdata = rd_act ? ecl_act_ff[i] : ecl_buf_ff[i];
                        end
                    end
                    for (int i = 0; i < `NUM_LS; i++) begin
                        if (reg_addr_i == `ADDR_LS_BASE + 10'(i)) begin
                            nxt_rdata = rd_act ? ls_act_ff[i] : ls_buf_ff[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ----------------------------------------------------------------
    // pll power-down sequencing
    // ----------------------------------------------------------------
    ckgen_pkg::pll_state_t pll_state_ff, nxt_pll_state;
    logic [1:0] pll_mode;

    always_comb begin
        pll_mode = pll_act_ff[`PLL_MODE_LSB +: 2];
        nxt_pll_state = pll_state_ff;
        unique case (pll_state_ff)
            ckgen_pkg::PLL_ON: begin
                if (pll_mode == `PLL_MODE_ASYNC) begin
                    nxt_pll_state = ckgen_pkg::PLL_OFF;
                end else if (pll_mode == `PLL_MODE_SYNC) begin
                    nxt_pll_state = ckgen_pkg::PLL_WAIT_CP;
                end
            end
            ckgen_pkg::PLL_WAIT_CP: begin
                // an event seen before the mode went active does not count
                if (pll_mode == `PLL_MODE_ASYNC || cp_event_i) begin
                    nxt_pll_state = ckgen_pkg::PLL_OFF;
                end else if (pll_mode != `PLL_MODE_SYNC) begin
                    nxt_pll_state = ckgen_pkg::PLL_ON;
                end
            end
            ckgen_pkg::PLL_OFF: begin
                if (pll_mode != `PLL_MODE_ASYNC && pll_mode != `PLL_MODE_SYNC) begin
                    nxt_pll_state = ckgen_pkg::PLL_ON;
                end
            end
            default: begin
                nxt_pll_state = ckgen_pkg::PLL_ON;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_state_ff <= ckgen_pkg::PLL_ON;
        end else begin
            pll_state_ff <= nxt_pll_state;
        end
    end

    // ----------------------------------------------------------------
    // output alignment
    // ----------------------------------------------------------------
    logic align_hold;

    // every source holds outputs static; release runs the stretch then frees them
    assign align_hold = !rst_released
        || soft_rst_ff
        || dist_act_ff[`DIST_PD_BIT]
        || dist_act_ff[`DIST_ALIGN_BIT]
        || sleep;

    hold_stretch u_align (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .hold_i(align_hold),
        .busy_o(align_busy)
    );

    // ----------------------------------------------------------------
    // output controls
    // ----------------------------------------------------------------
    logic nxt_pll_pd, dist_pd;
    logic [11:0] nxt_ecl_mode, nxt_ecl_amp, nxt_ls_pol;
    logic [5:0] nxt_ecl_inv, nxt_ecl_en;
    logic [3:0] nxt_ls_pd, nxt_ls_diff, nxt_ls_a, nxt_ls_b;
    logic [1:0] mode_eff;

    always_comb begin
        dist_pd = dist_act_ff[`DIST_PD_BIT];
        nxt_pll_pd = sleep || (pll_state_ff == ckgen_pkg::PLL_OFF);
        mode_eff = `ECL_MODE_NORMAL;
        nxt_ecl_mode = 12'h000;
        nxt_ecl_amp = 12'h000;
        nxt_ecl_inv = 6'h00;
        nxt_ecl_en = 6'h00;
        for (int i = 0; i < `NUM_ECL; i++) begin
            // asleep forces safe-off so terminated loads stay protected
            mode_eff = sleep ? `ECL_MODE_SAFE : ecl_act_ff[i][`ECL_MODE_LSB +: 2];
            nxt_ecl_mode[2 * i +: 2] = mode_eff;
            nxt_ecl_amp[2 * i +: 2] = ecl_act_ff[i][`ECL_AMP_LSB +: 2];
            nxt_ecl_inv[i] = ecl_act_ff[i][`ECL_INV_BIT];
            nxt_ecl_en[i] = (mode_eff == `ECL_MODE_NORMAL) && !dist_pd;
        end
        nxt_ls_pd = 4'h0;
        nxt_ls_diff = 4'h0;
        nxt_ls_a = 4'h0;
        nxt_ls_b = 4'h0;
        nxt_ls_pol = 12'h000;
        for (int i = 0; i < `NUM_LS; i++) begin
            nxt_ls_pd[i] = ls_act_ff[i][`LS_PD_BIT] || sleep || dist_pd;
            nxt_ls_diff[i] = !nxt_ls_pd[i] && !ls_act_ff[i][`LS_SE_BIT];
            nxt_ls_a[i] = !nxt_ls_pd[i] && ls_act_ff[i][`LS_SE_BIT];
            nxt_ls_b[i] = nxt_ls_a[i] && ls_act_ff[i][`LS_B_EN_BIT];
            nxt_ls_pol[3 * i +: 3] = ls_act_ff[i][`LS_POL_LSB +: 3];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_pwr_dn_o <= 1'b0;
            osc_pwr_dn_o <= 1'b0;
            clkin_buf_pwr_dn_o <= 1'b0;
            div_pwr_dn_o <= 1'b0;
            dist_bias_off_o <= 1'b0;
            align_o <= 1'b1;
            soft_rst_active_o <= 1'b0;
            ecl_pd_mode_o <= 12'h000;
            ecl_amp_o <= 12'h000;
            ecl_invert_o <= 6'h00;
            ecl_enable_o <= 6'h00;
            ls_pwr_dn_o <= 4'hF;
            ls_diff_en_o <= 4'h0;
            ls_cmos_a_en_o <= 4'h0;
            ls_cmos_b_en_o <= 4'h0;
            ls_polarity_o <= 12'h000;
        end else begin
            pll_pwr_dn_o <= nxt_pll_pd;
            osc_pwr_dn_o <= sleep;
            clkin_buf_pwr_dn_o <= sleep;
            div_pwr_dn_o <= sleep;
            dist_bias_off_o <= dist_pd;
            align_o <= align_busy;
            soft_rst_active_o <= soft_rst_ff;
            ecl_pd_mode_o <= nxt_ecl_mode;
            ecl_amp_o <= nxt_ecl_amp;
            ecl_invert_o <= nxt_ecl_inv;
            ecl_enable_o <= nxt_ecl_en;
            ls_pwr_dn_o <= nxt_ls_pd;
            ls_diff_en_o <= nxt_ls_diff;
            ls_cmos_a_en_o <= nxt_ls_a;
            ls_cmos_b_en_o <= nxt_ls_b;
            ls_polarity_o <= nxt_ls_pol;
        end
    end
endmodule

// ==== ckgen_sva.sv ====
// assertions on the ports of the reset and power-down block
`timescale 1ns/1ps
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module ckgen_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // pins
    input wire logic chip_sleep_n_i,
    // power and alignment
    input wire logic pll_pwr_dn_o,
    input wire logic osc_pwr_dn_o,
    input wire logic clkin_buf_pwr_dn_o,
    input wire logic div_pwr_dn_o,
    input wire logic dist_bias_off_o,
    input wire logic align_o,
    input wire logic soft_rst_active_o,
    // outputs
    input wire logic [11:0] ecl_pd_mode_o,
    input wire logic [5:0] ecl_enable_o,
    input wire logic [3:0] ls_pwr_dn_o,
    input wire logic [3:0] ls_diff_en_o,
    input wire logic [3:0] ls_cmos_a_en_o,
    input wire logic [3:0] ls_cmos_b_en_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // pin goes through two sync flops and an output register
    property p_sleep_core;
        !chip_sleep_n_i |-> ##3 (osc_pwr_dn_o && div_pwr_dn_o && clkin_buf_pwr_dn_o && pll_pwr_dn_o);
    endproperty
    a_sleep_core: assert property (p_sleep_core) else $error("core not off asleep");
    property p_sleep_ecl;
        !chip_sleep_n_i |-> ##3 (ecl_enable_o == 6'h00 && ecl_pd_mode_o == 12'hAAA);
    endproperty
    a_sleep_ecl: assert property (p_sleep_ecl) else $error("ecl not safe asleep");
    property p_wake;
        // one extra cycle: the sync flops leave reset one edge after the pin is seen
        chip_sleep_n_i [*5] |-> !osc_pwr_dn_o && !div_pwr_dn_o;
    endproperty
    a_wake: assert property (p_wake) else $error("still asleep after pin high");
    property p_rst;
        disable iff (1'b0) !rstn_i |-> align_o && ls_pwr_dn_o == 4'hF && ecl_enable_o == 6'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not at reset state");
    property p_soft;
        soft_rst_active_o |=> align_o;
    endproperty
    a_soft: assert property (p_soft) else $error("no alignment hold in soft reset");
    property p_fall;
        $fell(align_o) |-> $past(align_o, 8);
    endproperty
    a_fall: assert property (p_fall) else $error("alignment too short");
    property p_dist;
        dist_bias_off_o |-> ecl_enable_o == 6'h00 && align_o && ls_pwr_dn_o == 4'hF;
    endproperty
    a_dist: assert property (p_dist) else $error("outputs live in dist pd");
    property p_ls_pd;
        ((ls_cmos_a_en_o | ls_cmos_b_en_o | ls_diff_en_o) & ls_pwr_dn_o) == 4'h0;
    endproperty
    a_ls_pd: assert property (p_ls_pd) else $error("low-swing on while off");
endmodule
bind clock_gen_reset_powerdown_ctrl ckgen_sva chk (.*);

// ==== cp_src.sv ====
// charge pump event source on the far side of the pll control
`timescale 1ns/1ps
module cp_src (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // control
    input wire logic run_i,
    // event pulse
    output logic cp_event_o
);
    logic [2:0] cnt_ff;
    // one pulse every 5 cycles; silent when stopped so a waiting pll is seen
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= (cnt_ff == 3'h4) ? 3'h0 : cnt_ff + 3'h1;
        end
    end
    assign cp_event_o = run_i && cnt_ff == 3'h4;
endmodule

// ==== tb_top.sv ====
// self-checking bench for the reset and power-down block
`timescale 1ns/1ps
module tb_top;
    logic mclk_i = 1'b0, rstn_i = 1'b1, chip_sleep_n_i = 1'b1, cp_run = 1'b0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_pend = 1'b0, cp_event_i;
    logic [9:0] reg_addr_i = 10'h000;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, v;
    logic pll_pwr_dn_o, osc_pwr_dn_o, clkin_buf_pwr_dn_o, div_pwr_dn_o;
    logic dist_bias_off_o, align_o, soft_rst_active_o;
    logic [11:0] ecl_pd_mode_o, ecl_amp_o, ls_polarity_o;
    logic [5:0] ecl_invert_o, ecl_enable_o;
    logic [3:0] ls_pwr_dn_o, ls_diff_en_o, ls_cmos_a_en_o, ls_cmos_b_en_o;
    logic [1:0] md [3] = '{2'h0, 2'h2, 2'h3};
    logic [7:0] exq [$];
    int bad_count = 0, comparisons = 0;
    clock_gen_reset_powerdown_ctrl uut (.*);
    cp_src far (.mclk_i(mclk_i), .rstn_i(rstn_i), .run_i(cp_run), .cp_event_o(cp_event_i));
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        exq.push_back(e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
    endtask
    // update, then wait for the outputs to settle
    task automatic upd();
        wr(10'h232, 8'h01);
        repeat (4) @(posedge mclk_i);
        #1;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_pend) begin
            chk(reg_rdata_o, exq.pop_front());
        end
        rd_pend <= reg_rd_i;
    end
    initial begin
        wt(6000);
        bad_count++;
        final_report();
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h34b0571a));
        // falling edge at time zero so the flops are reset before the first clock
        rstn_i <= 1'b0;
        repeat (16) @(posedge mclk_i);
        rstn_i <= 1'b1;
        wt(2);
        chk(align_o, 1);
        wr(10'h004, 8'h01);
        rd(10'h010, 8'h00);
        for (int i = 0; i < 6; i++) rd(10'h0F0 + 10'(i), 8'h08);
        rd(10'h140, 8'h00);
        rd(10'h3FF, 8'h00);
        wt(20);
        rd(10'h006, 8'h00);
        $display("test reset done");
        v = {3'h0, 1'($urandom), 2'($urandom), 2'h0};
        wr(10'h0F0, v);
        rd(10'h0F0, 8'h08);
        wr(10'h004, 8'h00);
        rd(10'h0F0, v);
        upd();
        chk(ecl_amp_o[1:0], v[3:2]);
        chk({ecl_enable_o[0], ecl_invert_o[0]}, {1'b1, v[4]});
        $display("test buffer done");
        wr(10'h010, 8'h01);
        upd();
        chk(pll_pwr_dn_o, 1);
        wr(10'h010, 8'h03);
        upd();
        chk(pll_pwr_dn_o, 1);
        wr(10'h010, 8'h02);
        upd();
        chk(pll_pwr_dn_o, 0);
        wr(10'h010, 8'h03);
        upd();
        wt(8);
        chk(pll_pwr_dn_o, 0);
        cp_run <= 1'b1;
        wt(8);
        chk(pll_pwr_dn_o, 1);
        cp_run <= 1'b0;
        $display("test pll done");
        wr(10'h000, 8'h24);
        wt(2);
        chk(soft_rst_active_o, 1);
        rd(10'h0F0, 8'h08);
        rd(10'h006, 8'h0C);
        wr(10'h000, 8'h00);
        wt(20);
        rd(10'h006, 8'h00);
        $display("test soft reset done");
        @(posedge mclk_i) chip_sleep_n_i <= 1'b0;
        v = {3'h0, 1'($urandom), 2'($urandom), 2'h0};
        wr(10'h0F1, v);
        upd();
        chk(ls_pwr_dn_o, 4'hF);
        wr(10'h004, 8'h01);
        rd(10'h0F1, v);
        rd(10'h006, 8'h07);
        @(posedge mclk_i) chip_sleep_n_i <= 1'b1;
        wt(6);
        chk(ecl_enable_o, 6'h3F);
        chk(ecl_amp_o[3:2], v[3:2]);
        $display("test sleep done");
        wr(10'h230, 8'h02);
        upd();
        chk(dist_bias_off_o, 1);
        wr(10'h230, 8'h01);
        upd();
        chk({dist_bias_off_o, align_o}, 2'h1);
        wr(10'h230, 8'h00);
        upd();
        wt(8);
        chk(align_o, 0);
        for (int i = 0; i < 3; i++) begin
            wr(10'h0F2, {6'h02, md[i]});
            upd();
            chk({ecl_pd_mode_o[5:4], ecl_enable_o[2]}, {md[i], md[i] == 2'h0});
        end
        $display("test dist done");
        v = {3'($urandom), 5'h18};
        wr(10'h143, v);
        upd();
        chk({ls_cmos_a_en_o[3], ls_cmos_b_en_o[3], ls_diff_en_o[3]}, 3'h6);
        chk(ls_polarity_o[11:9], v[7:5]);
        wr(10'h143, v | 8'h01);
        upd();
        chk({ls_cmos_a_en_o[3], ls_cmos_b_en_o[3], ls_pwr_dn_o[3]}, 3'h1);
        $display("test low-swing done");
        @(posedge mclk_i) rstn_i <= 1'b0;
        wt(2);
        chk(align_o, 1);
        @(posedge mclk_i) rstn_i <= 1'b1;
        rd(10'h143, 8'h00);
        wt(3);
        $display("test hard reset done");
        final_report();
    end
endmodule
